// File: sdram_aux_defs.svh
// Constants for the auxiliary SDRAM command controller.
// Assumes a 40 MHz controller clock; times are in nanoseconds, refresh periods in microseconds.
`ifndef SDRAM_AUX_DEFS_SVH
`define SDRAM_AUX_DEFS_SVH
`define CLK_PERIOD_NS 25
`define TRC_NS 66
`define TRP_NS 20
`define POWERDOWN_EXIT_TIME_NS 25
`define TRC_CYC ((`TRC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRP_CYC ((`TRP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERDOWN_EXIT_TIME_CYC ((`POWERDOWN_EXIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_COUNT 4096
`define REFRESH_PERIOD_US 64000
`define REFRESH_PERIOD_IND_US 32000
`define MODE_CL_LSB 4
`define MODE_BL_LSB 0
`define CL_CODE_2 3'h2
`define CL_CODE_3 3'h3
`define BL_CODE_1 3'h0
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_CODE_FULL 3'h7
`define BURST_REFRESH_ADDR 4'h0
`endif

// File: sdram_aux_pkg.sv
// Types shared by the auxiliary SDRAM command controller.
// Assumes sdram_aux_defs.svh supplies the numeric constants.
package sdram_aux_pkg;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_BURST_STOP = 3'h1,
        CMD_AUTO_REFRESH = 3'h2,
        CMD_SELF_REFRESH = 3'h3,
        CMD_POWER_DOWN = 3'h4,
        CMD_WAKE = 3'h5
    } req_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
    } pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_REF_WAIT = 7'h02,
        ST_SELF = 7'h04,
        ST_SELF_EXIT = 7'h08,
        ST_PDOWN = 7'h10,
        ST_PD_EXIT = 7'h20,
        ST_BURST = 7'h40
    } state_t;
endpackage

// File: sdram_aux_mask.sv
// Byte mask register: holds one mask bit per byte lane.
// Assumes the controller supplies a write strobe and a clock enable.
`timescale 1ns/10ps
module sdram_aux_mask (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [3:0] mask_i,
    output logic [3:0] mask_o
);
    logic [3:0] mask_q;
    logic [3:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (wr_i) begin
            mask_d = mask_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= 4'hf;
        end else if (ce_i) begin
            mask_q <= mask_d;
        end
    end

    assign mask_o = mask_q;
endmodule

// File: sdram_aux_ctrl.sv
// Controller driving the auxiliary command set of a four-bank SDRAM.
// Assumes the SDRAM shares MCLK_I and that read/write sequencing is elsewhere.
// Summary of operation
// - Chip select low with row, column strobe and write enable high is NOP.
// - Issue 4096 auto refreshes every 64 ms, 32 ms industrial; the controller refreshes only on request.
// - After auto refresh issue only NOPs for the row cycle time.
// - Auto refresh only with banks idle and clock enable high before.
// - Meet precharge time between consecutive auto refreshes.
// - Self refresh is refresh code with clock enable low, held low.
// - Exit self refresh by running the clock, then raising clock enable.
// - After self refresh exit only NOP or deselect for row cycle time.
// - Burst refresh users should refresh all rows around self refresh; the controller leaves this to the requester.
// - Do not stay suspended or powered down beyond 64 ms; the controller stays there until a wake request.
// - Raising clock enable resumes; wait exit time plus one cycle.
`timescale 1ns/10ps
`include "sdram_aux_defs.svh"
module sdram_aux_ctrl (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic REQ_VALID_I,
    input wire sdram_aux_pkg::req_cmd_t REQ_CMD_I,
    input wire logic BANKS_IDLE_I,
    input wire logic BURST_ACTIVE_I,
    input wire logic BURST_AUTO_PRE_I,
    input wire logic MASK_WR_I,
    input wire logic [3:0] MASK_I,
    input wire logic [2:0] MODE_CL_I,
    input wire logic [2:0] MODE_BL_I,
    output logic REQ_READY_O,
    output sdram_aux_pkg::pins_t PINS_O,
    output logic [3:0] DQM_O,
    output logic [3:0] READ_TAIL_O,
    output logic [8:0] BURST_WORDS_O,
    output logic MODE_BAD_O,
    output logic BUSY_O
);
    localparam int TRC_C = `TRC_CYC;
    localparam int TRP_C = `TRP_CYC;
    localparam int POWERDOWN_EXIT_TIME_C = `POWERDOWN_EXIT_TIME_CYC;

    sdram_aux_pkg::state_t state_q;
    sdram_aux_pkg::state_t state_d;
    sdram_aux_pkg::pins_t pins_q;
    sdram_aux_pkg::pins_t pins_d;
    logic [3:0] wait_q;
    logic [3:0] wait_d;
    logic [3:0] tail_q;
    logic [3:0] tail_d;
    logic [8:0] words_q;
    logic [8:0] words_d;
    logic bad_q;
    logic bad_d;
    logic take;

    function automatic logic [3:0] cl_cycles(input logic [2:0] code);
        if (code == `CL_CODE_3) begin
            cl_cycles = 4'h3;
        end else if (code == `CL_CODE_2) begin
            cl_cycles = 4'h2;
        end else begin
            cl_cycles = 4'h0;
        end
    endfunction

    function automatic logic [8:0] bl_words(input logic [2:0] code);
        unique case (code)
            `BL_CODE_1: bl_words = 9'h001;
            `BL_CODE_2: bl_words = 9'h002;
            `BL_CODE_4: bl_words = 9'h004;
            `BL_CODE_8: bl_words = 9'h008;
            `BL_CODE_FULL: bl_words = 9'h000;
            default: bl_words = 9'h000;
        endcase
    endfunction

    function automatic sdram_aux_pkg::pins_t nop_pins(input logic cke);
        nop_pins = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: cke};
    endfunction

    assign take = REQ_VALID_I && REQ_READY_O;

    always_comb begin
        REQ_READY_O = 1'b0;
        unique case (state_q)
            sdram_aux_pkg::ST_IDLE: REQ_READY_O = 1'b1;
            sdram_aux_pkg::ST_SELF: REQ_READY_O = (REQ_CMD_I == sdram_aux_pkg::CMD_WAKE);
            sdram_aux_pkg::ST_PDOWN: REQ_READY_O = (REQ_CMD_I == sdram_aux_pkg::CMD_WAKE);
            sdram_aux_pkg::ST_BURST: REQ_READY_O = (REQ_CMD_I == sdram_aux_pkg::CMD_WAKE);
            default: REQ_READY_O = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        wait_d = (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
        tail_d = (tail_q != 4'h0) ? tail_q - 4'h1 : 4'h0;
        words_d = bl_words(MODE_BL_I);
        bad_d = (cl_cycles(MODE_CL_I) == 4'h0);
        pins_d = nop_pins(pins_q.cke);
        unique case (state_q)
            sdram_aux_pkg::ST_IDLE: begin
                if (take) begin
                    unique case (REQ_CMD_I)
                        sdram_aux_pkg::CMD_BURST_STOP: begin
                            if (BURST_ACTIVE_I && !BURST_AUTO_PRE_I) begin
                                pins_d.we_n = 1'b0;
                                tail_d = cl_cycles(MODE_CL_I);
                            end
                        end
                        sdram_aux_pkg::CMD_AUTO_REFRESH: begin
                            if (BANKS_IDLE_I && pins_q.cke) begin
                                pins_d.ras_n = 1'b0;
                                pins_d.cas_n = 1'b0;
                                wait_d = 4'(TRC_C + TRP_C);
                                state_d = sdram_aux_pkg::ST_REF_WAIT;
                            end
                        end
                        sdram_aux_pkg::CMD_SELF_REFRESH: begin
                            if (BANKS_IDLE_I && pins_q.cke) begin
                                pins_d.ras_n = 1'b0;
                                pins_d.cas_n = 1'b0;
                                pins_d.cke = 1'b0;
                                state_d = sdram_aux_pkg::ST_SELF;
                            end
                        end
                        sdram_aux_pkg::CMD_POWER_DOWN: begin
                            pins_d = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                       cke: 1'b0};
                            state_d = BURST_ACTIVE_I ? sdram_aux_pkg::ST_BURST
                                                     : sdram_aux_pkg::ST_PDOWN;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            sdram_aux_pkg::ST_REF_WAIT: begin
                if (wait_q == 4'h1) begin
                    state_d = sdram_aux_pkg::ST_IDLE;
                end
            end
            sdram_aux_pkg::ST_SELF: begin
                pins_d.cke = 1'b0;
                if (take) begin
                    pins_d = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                               cke: 1'b1};
                    wait_d = 4'(TRC_C);
                    state_d = sdram_aux_pkg::ST_SELF_EXIT;
                end
            end
            sdram_aux_pkg::ST_PDOWN,
            sdram_aux_pkg::ST_BURST: begin
                pins_d.cke = 1'b0;
                if (take) begin
                    pins_d.cke = 1'b1;
                    wait_d = 4'(POWERDOWN_EXIT_TIME_C + 1);
                    state_d = sdram_aux_pkg::ST_PD_EXIT;
                end
            end
            sdram_aux_pkg::ST_SELF_EXIT,
            sdram_aux_pkg::ST_PD_EXIT: begin
                if (wait_q == 4'h1) begin
                    state_d = sdram_aux_pkg::ST_IDLE;
                end
            end
            default: state_d = sdram_aux_pkg::ST_IDLE;
        endcase
    end

    // Clock enable low freezes every register, including the wait counters.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state_q <= sdram_aux_pkg::ST_IDLE;
            pins_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1};
            wait_q <= 4'h0;
            tail_q <= 4'h0;
            words_q <= 9'h000;
            bad_q <= 1'b0;
        end else if (CE_I) begin
            state_q <= state_d;
            pins_q <= pins_d;
            wait_q <= wait_d;
            tail_q <= tail_d;
            words_q <= words_d;
            bad_q <= bad_d;
        end
    end

    // Masks feed both write blocking and read output disable.
    sdram_aux_mask u_mask (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .wr_i(MASK_WR_I),
        .mask_i(MASK_I),
        .mask_o(DQM_O)
    );

    assign PINS_O = pins_q;
    assign READ_TAIL_O = tail_q;
    assign BURST_WORDS_O = words_q;
    assign MODE_BAD_O = bad_q;
    assign BUSY_O = (state_q != sdram_aux_pkg::ST_IDLE);

    // The refresh rate is left to the requester.
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    AST_REF_PINS: assert property ((CE_I && take && state_q == sdram_aux_pkg::ST_IDLE
        && REQ_CMD_I == sdram_aux_pkg::CMD_AUTO_REFRESH && BANKS_IDLE_I && pins_q.cke)
        |=> (!PINS_O.ras_n && !PINS_O.cas_n && PINS_O.we_n && PINS_O.cke))
        else $error("Auto refresh not driven.");
    AST_REF_NOPS: assert property ((CE_I
        && $rose(state_q == sdram_aux_pkg::ST_REF_WAIT)) ##1 CE_I
        |-> (PINS_O.ras_n && PINS_O.cas_n && PINS_O.we_n))
        else $error("Command during refresh wait.");
    AST_REF_GAP: assert property ($rose(state_q == sdram_aux_pkg::ST_REF_WAIT)
        |-> (state_q == sdram_aux_pkg::ST_REF_WAIT)[*4])
        else $error("Refresh spacing too short.");
    AST_SELF_CKE: assert property ((state_q == sdram_aux_pkg::ST_SELF) |-> !PINS_O.cke)
        else $error("Clock enable high in self refresh.");
    AST_SELF_EXIT: assert property ($rose(state_q == sdram_aux_pkg::ST_SELF_EXIT)
        |-> (PINS_O.cke && PINS_O.cs_n))
        else $error("Bad self refresh exit.");
    AST_SELF_WAIT: assert property ($rose(state_q == sdram_aux_pkg::ST_SELF_EXIT)
        |-> (PINS_O.ras_n && PINS_O.cas_n && PINS_O.we_n)[*3])
        else $error("Command too soon after self refresh.");
    AST_STOP_AP: assert property ((CE_I && take && state_q == sdram_aux_pkg::ST_IDLE
        && REQ_CMD_I == sdram_aux_pkg::CMD_BURST_STOP && BURST_AUTO_PRE_I)
        |=> PINS_O.we_n)
        else $error("Burst stop on auto precharge burst.");
    AST_STOP_TAIL: assert property ((CE_I && take && state_q == sdram_aux_pkg::ST_IDLE
        && REQ_CMD_I == sdram_aux_pkg::CMD_BURST_STOP && BURST_ACTIVE_I && !BURST_AUTO_PRE_I
        && MODE_CL_I == `CL_CODE_3) |=> (!PINS_O.we_n && READ_TAIL_O == 4'h3))
        else $error("Read tail wrong after stop.");
    AST_IDLE_NOP: assert property ((state_q == sdram_aux_pkg::ST_IDLE
        && !take && CE_I) |=> (PINS_O.cs_n || (PINS_O.ras_n && PINS_O.cas_n && PINS_O.we_n)))
        else $error("Spurious command in idle.");
    AST_PD_EXIT: assert property ($rose(state_q == sdram_aux_pkg::ST_PD_EXIT)
        |-> PINS_O.cke ##1 (state_q == sdram_aux_pkg::ST_PD_EXIT))
        else $error("Power-down exit too short.");

    COV_REFRESH: cover property ($rose(state_q == sdram_aux_pkg::ST_REF_WAIT));
    COV_SELF: cover property ($rose(state_q == sdram_aux_pkg::ST_SELF_EXIT));
    COV_PDOWN: cover property ($rose(state_q == sdram_aux_pkg::ST_PD_EXIT));
endmodule

// File: sdram_aux_mem_model.sv
// Behavioural model of the memory device sitting on the controller's command pins.
// Assumes pins are sampled on the rising edge of the shared controller clock.
`timescale 1ns/10ps
`include "sdram_aux_defs.svh"
module sdram_aux_mem_model (
    input wire logic clk_i,
    input wire sdram_aux_pkg::pins_t pins_i,
    output logic [11:0] row_o,
    output logic self_o,
    output logic pdown_o,
    output logic [7:0] viol_o,
    output logic late_o
);
    logic cke_prev;
    logic is_nop;
    logic is_ref;
    int wait_cnt;
    int win_cyc;
    int win_refs;
    int quiet_cyc;
    // Deselect and the all-high pattern both leave the device untouched.
    assign is_nop = pins_i.cs_n | (pins_i.ras_n & pins_i.cas_n & pins_i.we_n);
    assign is_ref = !pins_i.cs_n & !pins_i.ras_n & !pins_i.cas_n & pins_i.we_n;
    initial begin
        row_o = 12'h000;
        self_o = 1'b0;
        pdown_o = 1'b0;
        viol_o = 8'h00;
        cke_prev = 1'b1;
        wait_cnt = 0;
        late_o = 1'b0;
        win_cyc = 0;
        win_refs = 0;
        quiet_cyc = 0;
    end
    // The window checks only matter on long runs; a short run never reaches a window end.
    always @(posedge clk_i) begin
        win_cyc <= win_cyc + 1;
        quiet_cyc <= pdown_o ? quiet_cyc + 1 : 0;
        if (is_ref && pins_i.cke && !self_o && !pdown_o) begin
            win_refs <= win_refs + 1;
        end
        if (win_cyc >= `REFRESH_PERIOD_US * (1000 / `CLK_PERIOD_NS) - 1) begin
            if (win_refs < `REFRESH_COUNT) begin
                late_o <= 1'b1;
            end
            win_cyc <= 0;
            win_refs <= 0;
        end
        if (quiet_cyc > `REFRESH_PERIOD_US * (1000 / `CLK_PERIOD_NS)) begin
            late_o <= 1'b1;
        end
    end
    // Violations are counted, not flagged at once, so one slip does not hide later ones.
    always @(posedge clk_i) begin
        cke_prev <= pins_i.cke;
        if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
        if (self_o || pdown_o) begin
            if (pins_i.cke) begin
                if (!is_nop) begin
                    viol_o <= viol_o + 8'h01;
                end
                wait_cnt <= self_o ? `TRC_CYC : `POWERDOWN_EXIT_TIME_CYC;
                self_o <= 1'b0;
                pdown_o <= 1'b0;
            end
        end else if (wait_cnt > 0 && !is_nop) begin
            viol_o <= viol_o + 8'h01;
        end else if (is_ref && pins_i.cke) begin
            if (!cke_prev) begin
                viol_o <= viol_o + 8'h01;
            end
            row_o <= row_o + 12'h001;
            wait_cnt <= `TRC_CYC + `TRP_CYC;
        end else if (is_ref) begin
            self_o <= 1'b1;
        end else if (!pins_i.cke) begin
            pdown_o <= 1'b1;
        end
    end
endmodule

// File: sdram_aux_command_control_tb.sv
// Self-checking bench for the auxiliary command controller and the memory model.
// Assumes inputs change at the falling edge and the design samples on the rising edge.
`timescale 1ns/10ps
module sdram_aux_command_control_tb;
    logic clk, rst, ce, vld, idle, bact, bpre, mwr, rdy, bad, busy, self_m, pdown_m, late;
    sdram_aux_pkg::req_cmd_t cmd;
    sdram_aux_pkg::pins_t pins;
    logic [3:0] mask, dqm, tail, m;
    logic [2:0] cl, bl;
    logic [8:0] words;
    logic [11:0] row, base;
    logic [7:0] viol;
    logic [31:0] lfsr;
    int err_total, comparisons, n, t;
    sdram_aux_ctrl i_dut (.MCLK_I(clk), .RST_I(rst), .CE_I(ce), .REQ_VALID_I(vld),
        .REQ_CMD_I(cmd), .BANKS_IDLE_I(idle), .BURST_ACTIVE_I(bact), .BURST_AUTO_PRE_I(bpre),
        .MASK_WR_I(mwr), .MASK_I(mask), .MODE_CL_I(cl), .MODE_BL_I(bl), .REQ_READY_O(rdy),
        .PINS_O(pins), .DQM_O(dqm), .READ_TAIL_O(tail), .BURST_WORDS_O(words),
        .MODE_BAD_O(bad), .BUSY_O(busy));
    sdram_aux_mem_model i_mem (.clk_i(clk), .pins_i(pins), .row_o(row), .self_o(self_m),
        .pdown_o(pdown_m), .viol_o(viol), .late_o(late));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [8:0] exp_words(input logic [2:0] c);
        return c[2] ? 9'h000 : 9'h001 << c;
    endfunction
    function automatic logic exp_bad(input logic [2:0] c);
        return !(c == 3'h2 || c == 3'h3);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Lets one edge pass first, so valid never falls and rises in one step between calls.
    // Returns at the falling edge after the request was taken.
    task automatic issue(input sdram_aux_pkg::req_cmd_t c);
        int k;
        k = 0;
        @(negedge clk);
        vld = 1'b1;
        cmd = c;
        while (rdy !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        vld = 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        lfsr = 32'hbdd47e06;
        err_total = 0;
        comparisons = 0;
        {rst, ce, vld, idle, bact, bpre, mwr} = 7'b1101000;
        cmd = sdram_aux_pkg::CMD_NONE;
        mask = 4'h0;
        cl = 3'h2;
        bl = 3'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(16'({pins.cs_n, pins.cke}), 16'h0003, "reset pins");
        chk(16'(dqm), 16'h000f, "reset mask");
        chk(16'({busy, rdy}), 16'h0001, "reset busy ready");
        $display("test reset done");
        n = 2 + int'(rnd() & 32'h3);
        base = row;
        for (int i = 0; i < n; i++) begin
            issue(sdram_aux_pkg::CMD_AUTO_REFRESH);
            chk(16'(pins), 16'h0003, "refresh pins");
            chk(16'({busy, rdy}), 16'h0002, "refresh wait");
        end
        @(negedge clk);
        chk(16'(row), 16'(base + 12'(n)), "refresh rows");
        idle = 1'b0;
        issue(sdram_aux_pkg::CMD_AUTO_REFRESH);
        chk(16'(pins), 16'h000f, "refresh banks busy");
        idle = 1'b1;
        $display("test refresh done");
        for (int k = 0; k < 4; k++) begin
            cl = k[0] ? 3'h3 : 3'h2;
            bpre = k[1];
            bact = 1'b1;
            issue(sdram_aux_pkg::CMD_BURST_STOP);
            chk(16'(pins), bpre ? 16'h000f : 16'h000d, "stop pins");
            t = 0;
            repeat (8) begin
                if (tail !== 4'h0) t++;
                @(negedge clk);
            end
            chk(16'(t), bpre ? 16'h0000 : 16'(cl), "read tail");
        end
        {bact, bpre} = 2'b00;
        $display("test burst stop done");
        for (int c = 0; c < 8; c++) begin
            cl = 3'(c);
            bl = 3'(c);
            @(negedge clk);
            chk(16'(bad), 16'(exp_bad(cl)), "latency code");
            chk(16'(words), 16'(exp_words(bl)), "burst words");
        end
        cl = 3'h2;
        $display("test mode codes done");
        repeat (4) begin
            m = 4'(rnd());
            mask = m;
            mwr = 1'b1;
            @(negedge clk);
            mwr = 1'b0;
            mask = ~m;
            chk(16'(dqm), 16'(m), "mask load");
            @(negedge clk);
            chk(16'(dqm), 16'(m), "mask hold");
        end
        $display("test mask done");
        ce = 1'b0;
        base = row;
        vld = 1'b1;
        cmd = sdram_aux_pkg::CMD_AUTO_REFRESH;
        repeat (3) @(negedge clk);
        chk(16'(row), 16'(base), "frozen refresh");
        ce = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        chk(16'(pins), 16'h0003, "thawed refresh");
        $display("test clock enable done");
        issue(sdram_aux_pkg::CMD_SELF_REFRESH);
        chk(16'(pins), 16'h0002, "self entry");
        t = 0;
        repeat (6) begin
            @(negedge clk);
            if (pins.cke !== 1'b0) t++;
        end
        chk(16'({16'(t), self_m}), 16'h0001, "self hold");
        issue(sdram_aux_pkg::CMD_WAKE);
        chk(16'({pins.cs_n, pins.cke, busy}), 16'h0007, "self exit");
        issue(sdram_aux_pkg::CMD_AUTO_REFRESH);
        chk(16'(pins), 16'h0003, "refresh after self");
        $display("test self refresh done");
        for (int k = 0; k < 2; k++) begin
            bact = k[0];
            issue(sdram_aux_pkg::CMD_POWER_DOWN);
            @(negedge clk);
            chk(16'({pins.cke, pdown_m}), 16'h0001, "power down");
            issue(sdram_aux_pkg::CMD_WAKE);
            chk(16'(pins.cke), 16'h0001, "wake");
            bact = 1'b0;
            issue(sdram_aux_pkg::CMD_AUTO_REFRESH);
            chk(16'(pins), 16'h0003, "refresh after wake");
        end
        $display("test power down done");
        repeat (6) @(negedge clk);
        chk(16'(viol), 16'h0000, "spacing violations");
        chk(16'(late), 16'h0000, "refresh rate");
        summarize();
    end
endmodule
